// file: core/icp_arbiter.sv
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// highest-level pending source, combinational
// ************************************************************
module icp_arbiter (
    input  wire logic [9:0]           pend_i,
    input  wire logic [29:0]          level_i,
    input  wire logic [2:0]           cpu_level_i,
    output var  icp_pkg::icp_grant_t  grant_o
);

    always_comb begin
        grant_o = '0;
        for (int i = 0; i < 10; i++) begin
            // a level of zero is never above cpu level, so disabled sources drop out here
            if (pend_i[i] && (level_i[3*i +: 3] > cpu_level_i)
                && (!grant_o.valid || level_i[3*i +: 3] > grant_o.level)) begin
                grant_o.valid  = 1'b1;
                grant_o.source = 4'(i);
                grant_o.level  = level_i[3*i +: 3];
            end
        end
    end

endmodule

`default_nettype wire

// file: core/icp_defs.svh
`ifndef ICP_DEFS_SVH
`define ICP_DEFS_SVH

// ************************************************************
// register byte addresses
// ************************************************************
`define ICP_ADDR_CTRL2      12'h000
`define ICP_ADDR_PRIO8      12'h004
`define ICP_ADDR_PRIO9      12'h008
`define ICP_ADDR_IRQ_STAT   12'h00C
`define ICP_ADDR_IRQ_MASK   12'h010
`define ICP_ADDR_CPU_LEVEL  12'h014
`define ICP_ADDR_GRANT      12'h018

// ************************************************************
// field positions
// ************************************************************
`define ICP_ALT_VECTOR_TABLE_SELECT_BIT      15
`define ICP_HOLD_BIT        14
`define ICP_SPB_EVT_LSB     4
`define ICP_SPB_FLT_LSB     0
`define ICP_CAP5_LSB        12
`define ICP_CAP4_LSB        8
`define ICP_CAP3_LSB        4

// ************************************************************
// reset values and masks
// ************************************************************
`define ICP_PRIO_RESET      3'h4
`define ICP_PRIO_OFF        3'h0
`define ICP_CTRL2_WMASK     16'h801F
`define ICP_PRIO8_RESET     16'h0044
`define ICP_PRIO9_RESET     16'h4440
`define ICP_NSRC            10
`define ICP_STAT_W          10

`endif

// file: core/icp_pkg.sv
package icp_pkg;

    typedef logic [2:0] icp_prio_t;

    typedef struct packed {
        logic        alt_vector_table_select;
        logic [4:0]  edge_polarity;
        icp_prio_t   serial_port_b_event_priority;
        icp_prio_t   serial_port_b_fault_priority;
        icp_prio_t   capture_ch5_priority;
        icp_prio_t   capture_ch4_priority;
        icp_prio_t   capture_ch3_priority;
    } icp_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [3:0]  source;
        icp_prio_t   level;
    } icp_grant_t;

    typedef enum logic [1:0] {
        ICP_IDLE  = 2'b01,
        ICP_DATA  = 2'b10
    } icp_bus_state_t;

endpackage

// file: core/icp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "icp_defs.svh"

// How it works
// - the alt vector table select bit, reset 0, picks the alternate table when 1 and the standard one when 0.
// - each of five external inputs has a polarity bit, 1 for falling edge and 0 for rising, reset 0.
// - the serial port b event priority sits at bits 6..4 of priority register eight, 111 being level 7.
// - the serial port b fault priority sits at bits 2..0 of the same register with the same coding.
// - a priority of 000 disables its source so no request goes to the core.
// - codes 001 to 111 give levels 1 to 7, 7 highest.
// - every priority field resets to 100, level 4.
// - capture channels 5, 4, 3 have priorities at bits 14..12, 10..8, 6..4 of register nine.
// - unimplemented bits read 0 and ignore writes.
module icp_top (
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    input  wire logic         hsel_i,
    input  wire logic [11:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic      [31:0]  hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    input  wire logic [4:0]   ext_irq_i,
    input  wire logic         serial_evt_i,
    input  wire logic         serial_flt_i,
    input  wire logic [2:0]   capture_evt_i,
    input  wire logic         irq_hold_instruction_active_i,
    output logic              irq_o,
    output logic              irq_req_o,
    output logic [3:0]        irq_source_o,
    output logic [2:0]        irq_level_o,
    output logic              alt_vector_table_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        icp_pkg::icp_bus_state_t  bus;
        logic                     wr;
        logic [11:0]              addr;
        icp_pkg::icp_cfg_t        cfg;
        logic                     hold;
        logic [2:0]               cpu_level;
        logic [9:0]               stat;
        logic [9:0]               mask;
        logic [4:0]               ext_s1;
        logic [4:0]               ext_s2;
        logic [4:0]               ext_s3;
        logic                     hold_s1;
        logic                     hold_s2;
        logic [31:0]              rdata;
        logic                     irq;
        icp_pkg::icp_grant_t      grant;
    } icp_state_t;

    icp_state_t s_q;
    icp_state_t s_d;

    logic [9:0]          pend;
    logic [29:0]         levels;
    icp_pkg::icp_grant_t arb;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] read_reg(input icp_state_t s, input logic [11:0] a);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            `ICP_ADDR_CTRL2: begin
                v[`ICP_ALT_VECTOR_TABLE_SELECT_BIT] = s.cfg.alt_vector_table_select;
                v[`ICP_HOLD_BIT]   = s.hold;
                v[4:0]             = s.cfg.edge_polarity;
            end
            `ICP_ADDR_PRIO8: begin
                v[`ICP_SPB_EVT_LSB +: 3] = s.cfg.serial_port_b_event_priority;
                v[`ICP_SPB_FLT_LSB +: 3] = s.cfg.serial_port_b_fault_priority;
            end
            `ICP_ADDR_PRIO9: begin
                v[`ICP_CAP5_LSB +: 3] = s.cfg.capture_ch5_priority;
                v[`ICP_CAP4_LSB +: 3] = s.cfg.capture_ch4_priority;
                v[`ICP_CAP3_LSB +: 3] = s.cfg.capture_ch3_priority;
            end
            `ICP_ADDR_IRQ_STAT:  v[9:0] = s.stat;
            `ICP_ADDR_IRQ_MASK:  v[9:0] = s.mask;
            `ICP_ADDR_CPU_LEVEL: v[2:0] = s.cpu_level;
            `ICP_ADDR_GRANT:     v[7:0] = {s.grant.valid, s.grant.source, s.grant.level};
            default:             v = 16'h0000;
        endcase
        return v;
    endfunction

    // ************************************************************
    // arbitration
    // ************************************************************
    always_comb begin
        // source i owns bits 3i+2..3i; ext sources 0..4 sit at level 0 and never win
        levels = {s_q.cfg.capture_ch3_priority, s_q.cfg.capture_ch4_priority,
                  s_q.cfg.capture_ch5_priority, s_q.cfg.serial_port_b_fault_priority,
                  s_q.cfg.serial_port_b_event_priority, 15'h0000};
        // ext inputs carry no priority field here; they join at the sticky status only
        pend = s_q.stat & s_q.mask;
    end

    icp_arbiter u_arb (
        .pend_i      (pend),
        .level_i     (levels),
        .cpu_level_i (s_q.cpu_level),
        .grant_o     (arb)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [4:0]  ext_edge;
        logic [9:0]  events;
        logic [9:0]  w1c;
        logic [15:0] wd;
        ext_edge = 5'h00;
        events   = 10'h000;
        w1c      = 10'h000;
        wd       = hwdata_i[15:0];
        s_d      = s_q;

        // ext pins pass two flops and the hold pin three before anything looks at them
        s_d.ext_s1  = ext_irq_i;
        s_d.ext_s2  = s_q.ext_s1;
        s_d.ext_s3  = s_q.ext_s2;
        s_d.hold_s1 = irq_hold_instruction_active_i;
        s_d.hold_s2 = s_q.hold_s1;
        s_d.hold    = s_q.hold_s2;

        for (int i = 0; i < 5; i++) begin
            ext_edge[i] = s_q.cfg.edge_polarity[i] ? (s_q.ext_s3[i] & ~s_q.ext_s2[i])
                                                   : (~s_q.ext_s3[i] & s_q.ext_s2[i]);
        end

        // disabled priority sources never latch, so a later enable finds no stale request
        events[4:0] = ext_edge;
        events[5]   = serial_evt_i & (s_q.cfg.serial_port_b_event_priority != `ICP_PRIO_OFF);
        events[6]   = serial_flt_i & (s_q.cfg.serial_port_b_fault_priority != `ICP_PRIO_OFF);
        events[7]   = capture_evt_i[0] & (s_q.cfg.capture_ch5_priority != `ICP_PRIO_OFF);
        events[8]   = capture_evt_i[1] & (s_q.cfg.capture_ch4_priority != `ICP_PRIO_OFF);
        events[9]   = capture_evt_i[2] & (s_q.cfg.capture_ch3_priority != `ICP_PRIO_OFF);

        // ahb-lite slave, zero wait states
        unique case (s_q.bus)
            icp_pkg::ICP_IDLE: begin
                s_d.bus = icp_pkg::ICP_IDLE;
            end
            icp_pkg::ICP_DATA: begin
                s_d.bus = icp_pkg::ICP_IDLE;
                if (s_q.wr) begin
                    unique case (s_q.addr)
                        `ICP_ADDR_CTRL2: begin
                            s_d.cfg.alt_vector_table_select = wd[`ICP_ALT_VECTOR_TABLE_SELECT_BIT];
                            s_d.cfg.edge_polarity           = wd[4:0];
                        end
                        `ICP_ADDR_PRIO8: begin
                            s_d.cfg.serial_port_b_event_priority = wd[`ICP_SPB_EVT_LSB +: 3];
                            s_d.cfg.serial_port_b_fault_priority = wd[`ICP_SPB_FLT_LSB +: 3];
                        end
                        `ICP_ADDR_PRIO9: begin
                            s_d.cfg.capture_ch5_priority = wd[`ICP_CAP5_LSB +: 3];
                            s_d.cfg.capture_ch4_priority = wd[`ICP_CAP4_LSB +: 3];
                            s_d.cfg.capture_ch3_priority = wd[`ICP_CAP3_LSB +: 3];
                        end
                        `ICP_ADDR_IRQ_STAT:  w1c           = wd[9:0];
                        `ICP_ADDR_IRQ_MASK:  s_d.mask      = wd[9:0];
                        `ICP_ADDR_CPU_LEVEL: s_d.cpu_level = wd[2:0];
                        default: begin
                        end
                    endcase
                end
            end
            default: s_d.bus = icp_pkg::ICP_IDLE;
        endcase

        if (hsel_i && hready_i && htrans_i[1]) begin
            s_d.bus   = icp_pkg::ICP_DATA;
            s_d.wr    = hwrite_i;
            s_d.addr  = {haddr_i[11:2], 2'b00};
            s_d.rdata = {16'h0000, read_reg(s_q, {haddr_i[11:2], 2'b00})};
        end

        // a new event beats a clear in the same cycle
        s_d.stat  = (s_q.stat & ~w1c) | events;
        s_d.grant = arb;
        s_d.irq   = |(s_q.stat & s_q.mask);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            s_q                                  <= '0;
            s_q.bus                              <= icp_pkg::ICP_IDLE;
            s_q.cfg.serial_port_b_event_priority <= `ICP_PRIO_RESET;
            s_q.cfg.serial_port_b_fault_priority <= `ICP_PRIO_RESET;
            s_q.cfg.capture_ch5_priority         <= `ICP_PRIO_RESET;
            s_q.cfg.capture_ch4_priority         <= `ICP_PRIO_RESET;
            s_q.cfg.capture_ch3_priority         <= `ICP_PRIO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        hrdata_o           = s_q.rdata;
        hreadyout_o        = 1'b1;
        hresp_o            = 1'b0;
        irq_o              = s_q.irq;
        irq_req_o          = s_q.grant.valid;
        irq_source_o       = s_q.grant.source;
        irq_level_o        = s_q.grant.level;
        alt_vector_table_o = s_q.cfg.alt_vector_table_select;
    end

endmodule

`default_nettype wire

// file: testbench/icp_src_model.sv
`timescale 1ns/100ps
`default_nettype none

// ********************
// interrupt sources and core hold flag
// ********************
module icp_src_model (
    input  wire logic       clock_i,
    output var  logic [4:0] ext_irq_o,
    output var  logic [4:0] evt_o,
    output var  logic       hold_o
);
    initial begin
        ext_irq_o = 5'h00;
        evt_o = 5'h00;
        hold_o = 1'b0;
    end
    // evt_o: 0 serial event, 1 serial fault, 2..4 capture ch5..ch3; one-cycle pulse
    task automatic pulse(input int k);
        @(posedge clock_i);
        evt_o <= 5'h01 << k;
        @(posedge clock_i);
        evt_o <= 5'h00;
    endtask
    task automatic pin(input int k, input logic v);
        @(posedge clock_i);
        ext_irq_o[k] <= v;
    endtask
    task automatic hold(input logic v);
        @(posedge clock_i);
        hold_o <= v;
    endtask
endmodule

`default_nettype wire

// file: testbench/icp_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "icp_defs.svh"

// ********************
// port-level checks
// ********************
module icp_top_monitor (
    input wire logic        clock_i,
    input wire logic        srst_i,
    input wire logic        hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    input wire logic        irq_hold_instruction_active_i,
    input wire logic        irq_o,
    input wire logic        irq_req_o,
    input wire logic [3:0]  irq_source_o,
    input wire logic [2:0]  irq_level_o,
    input wire logic        alt_vector_table_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence rd_s;
        hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    endsequence
    sequence rd_ctrl_s;
        rd_s ##0 (haddr_i == `ICP_ADDR_CTRL2);
    endsequence
    sequence wr_ctrl_s;
        hsel_i && hready_i && htrans_i[1] && hwrite_i && (haddr_i == `ICP_ADDR_CTRL2);
    endsequence
    // data phase carries the word one cycle after the address phase
    property alt_p;
        logic v;
        (wr_ctrl_s ##1 (1'b1, v = hwdata_i[15])) |-> ##[1:2] (alt_vector_table_o == v);
    endproperty
    // the hold flag passes a synchroniser, so it must have been steady a while
    property hold_p(bit lvl);
        ((irq_hold_instruction_active_i == lvl)[*6] ##0 rd_ctrl_s) |=> (hrdata_o[14] == lvl);
    endproperty
    bus_okay_a: assert property (hreadyout_o && !hresp_o) else $error("bus answer not ready or not okay");
    alt_copy_a: assert property (alt_p) else $error("alt table output does not follow write");
    hold_set_a: assert property (hold_p(1'b1)) else $error("hold flag not shown");
    hold_clr_a: assert property (hold_p(1'b0)) else $error("hold flag not cleared");
    unmapped_zero_a: assert property ((rd_s ##0 (haddr_i > `ICP_ADDR_GRANT)) |=> (hrdata_o == 32'h0000_0000))
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_s |=> (hrdata_o[31:16] == 16'h0000)) else $error("upper half not zero");
    ctrl_resv_a: assert property (rd_ctrl_s |=> (hrdata_o[13:5] == 9'h000)) else $error("ctrl gap bits set");
    level_nz_a: assert property (irq_req_o |-> (irq_level_o != 3'h0)) else $error("level zero forwarded");
    src_range_a: assert property (irq_req_o |-> (irq_source_o inside {[4'h5:4'h9]}))
        else $error("forwarded source out of range");
    reset_out_a: assert property (disable iff (1'b0) srst_i |=> !irq_o && !irq_req_o && !alt_vector_table_o)
        else $error("outputs not cleared by reset");
endmodule

bind icp_top icp_top_monitor u_icp_top_monitor (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .irq_hold_instruction_active_i, .irq_o,
    .irq_req_o, .irq_source_o, .irq_level_o, .alt_vector_table_o);

`default_nettype wire

// file: testbench/icp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "icp_defs.svh"

module icp_top_tb;
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        hsel_i = 1'b0;
    logic [11:0] haddr_i = 12'h000;
    logic [1:0]  htrans_i = 2'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [31:0] hrdata_o, rd;
    logic        hreadyout_o, hresp_o, irq_o, irq_req_o, alt_o, hold;
    logic [3:0]  irq_source_o;
    logic [2:0]  irq_level_o;
    logic [4:0]  ext_irq, evt;
    int          miscompares = 0, n_compared = 0, cycles = 0, c;

    icp_src_model u_icp_src_model (.clock_i, .ext_irq_o(ext_irq), .evt_o(evt), .hold_o(hold));
    icp_top u_icp_top (.clock_i, .srst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
        .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .ext_irq_i(ext_irq), .serial_evt_i(evt[0]),
        .serial_flt_i(evt[1]), .capture_evt_i(evt[4:2]), .irq_hold_instruction_active_i(hold), .irq_o,
        .irq_req_o, .irq_source_o, .irq_level_o, .alt_vector_table_o(alt_o));

    initial forever #20 clock_i = ~clock_i;
    // whole run needs well under 2000 cycles
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    // ********************
    // bus and check tasks
    // ********************
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= d;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk($sformatf("reg %h", a), e, rd);
    endtask
    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ********************
    // tests
    // ********************
    initial begin
        repeat (16) @(posedge clock_i);
        srst_i <= 1'b0;
        rchk(`ICP_ADDR_CTRL2, 32'h0000_0000);
        rchk(`ICP_ADDR_PRIO8, 32'h0000_0044);
        rchk(`ICP_ADDR_PRIO9, 32'h0000_4440);
        xfer(`ICP_ADDR_CTRL2, 1'b1, 32'hFFFF_FFFF);
        rchk(`ICP_ADDR_CTRL2, 32'h0000_801F);
        chk("alt out", 32'h0000_0001, {31'h0, alt_o});
        xfer(`ICP_ADDR_PRIO8, 1'b1, 32'hFFFF_FFFF);
        rchk(`ICP_ADDR_PRIO8, 32'h0000_0077);
        xfer(`ICP_ADDR_PRIO9, 1'b1, 32'hFFFF_FFFF);
        rchk(`ICP_ADDR_PRIO9, 32'h0000_7770);
        xfer(12'h01C, 1'b1, 32'hFFFF_FFFF);
        rchk(12'h01C, 32'h0000_0000);
        // ext2 on falling edge, others rising; hold flag is read only
        xfer(`ICP_ADDR_CTRL2, 1'b1, 32'h0000_0004);
        u_icp_src_model.hold(1'b1);
        repeat (6) @(posedge clock_i);
        rchk(`ICP_ADDR_CTRL2, 32'h0000_4004);
        u_icp_src_model.hold(1'b0);
        repeat (6) @(posedge clock_i);
        rchk(`ICP_ADDR_CTRL2, 32'h0000_0004);
        chk("alt out", 32'h0000_0000, {31'h0, alt_o});
        xfer(`ICP_ADDR_IRQ_MASK, 1'b1, 32'h0000_03FF);
        u_icp_src_model.pin(1, 1'b1);
        u_icp_src_model.pin(2, 1'b1);
        repeat (6) @(posedge clock_i);
        rchk(`ICP_ADDR_IRQ_STAT, 32'h0000_0002);
        u_icp_src_model.pin(2, 1'b0);
        repeat (6) @(posedge clock_i);
        rchk(`ICP_ADDR_IRQ_STAT, 32'h0000_0006);
        chk("irq", 32'h0000_0001, {31'h0, irq_o});
        xfer(`ICP_ADDR_IRQ_MASK, 1'b1, 32'h0000_0000);
        repeat (3) @(posedge clock_i);
        chk("irq masked", 32'h0000_0000, {31'h0, irq_o});
        xfer(`ICP_ADDR_IRQ_STAT, 1'b1, 32'h0000_0006);
        rchk(`ICP_ADDR_IRQ_STAT, 32'h0000_0000);
        // event 3, fault 5, ch5 2, ch4 7, ch3 off
        xfer(`ICP_ADDR_IRQ_MASK, 1'b1, 32'h0000_03FF);
        xfer(`ICP_ADDR_PRIO8, 1'b1, 32'h0000_0035);
        xfer(`ICP_ADDR_PRIO9, 1'b1, 32'h0000_2700);
        for (c = 0; c < 5; c++) u_icp_src_model.pulse(c);
        repeat (3) @(posedge clock_i);
        rchk(`ICP_ADDR_IRQ_STAT, 32'h0000_01E0);
        rchk(`ICP_ADDR_GRANT, 32'h0000_00C7);
        xfer(`ICP_ADDR_IRQ_STAT, 1'b1, 32'h0000_0100);
        repeat (3) @(posedge clock_i);
        rchk(`ICP_ADDR_GRANT, 32'h0000_00B5);
        xfer(`ICP_ADDR_IRQ_STAT, 1'b1, 32'h0000_03FF);
        xfer(`ICP_ADDR_PRIO8, 1'b1, 32'h0000_0010);
        u_icp_src_model.pulse(0);
        for (c = 1; c < 8; c++) begin
            xfer(`ICP_ADDR_PRIO8, 1'b1, 32'(c) << 4);
            xfer(`ICP_ADDR_CPU_LEVEL, 1'b1, 32'(c - 1));
            repeat (3) @(posedge clock_i);
            chk("fwd level", 32'h0000_0008 | 32'(c), {28'h0, irq_req_o, irq_level_o});
            chk("fwd source", 32'h0000_0005, {28'h0, irq_source_o});
            xfer(`ICP_ADDR_CPU_LEVEL, 1'b1, 32'(c));
            repeat (3) @(posedge clock_i);
            chk("not fwd", 32'h0000_0000, {31'h0, irq_req_o});
        end
        summarize();
    end
endmodule

`default_nettype wire
